// ===== inc/eeac_pkg.sv
package eeac_pkg;

  // I/O space layout
  localparam int unsigned IO_AW     = 6;
  localparam logic [5:0]  OFS_SCRATCH0 = 6'h13;
  localparam logic [5:0]  OFS_CTRL     = 6'h1c;
  localparam logic [5:0]  OFS_DATA     = 6'h1d;
  localparam logic [5:0]  OFS_ADDR     = 6'h1e;

  // Control register fields
  localparam int unsigned BIT_MODE_HI = 5;
  localparam int unsigned BIT_MODE_LO = 4;
  localparam int unsigned BIT_IRQ_EN  = 3;
  localparam int unsigned BIT_ARM     = 2;
  localparam int unsigned BIT_TRIG    = 1;
  localparam int unsigned BIT_READ    = 0;

  // Array geometry and reset values
  localparam int unsigned NVM_AW       = 6;
  localparam int unsigned NVM_DW       = 8;
  localparam logic [7:0]  RST_DATA     = 8'h00;
  localparam logic [7:0]  RST_SCRATCH0 = 8'h00;
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [1:0]  PAD_ZERO     = 2'h0;

  // Program modes
  typedef enum logic [1:0] {
    EEAC_MODE_ATOMIC = 2'h0,
    EEAC_MODE_ERASE  = 2'h1,
    EEAC_MODE_WRITE  = 2'h2,
    EEAC_MODE_RSVD   = 2'h3
  } eeac_mode_t;

  // Controller states, Gray coded along idle, prog, commit
  typedef enum logic [1:0] {
    EEAC_ST_IDLE   = 2'h0,
    EEAC_ST_PROG   = 2'h1,
    EEAC_ST_COMMIT = 2'h3
  } eeac_state_t;

  // Timing, clock at 20 MHz
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_ATOMIC_NS   = 3400000;
  localparam int unsigned T_SPLIT_NS    = 1800000;
  localparam int unsigned ATOMIC_CYCLES = T_ATOMIC_NS / CLK_PERIOD_NS;
  localparam int unsigned SPLIT_CYCLES  = T_SPLIT_NS / CLK_PERIOD_NS;
  localparam logic [2:0]  ARM_WINDOW    = 3'h4;
  localparam logic [2:0]  STALL_PROG    = 3'h2;
  localparam logic [2:0]  STALL_READ    = 3'h4;

endpackage

// ===== verilog/eeac_mem.sv
`timescale 1ns/1ps
// Byte array with registered read and erase/write/and-write port
module eeac_mem #(
  parameter int unsigned AW = 6,
  parameter int unsigned DW = 8
) (
  input  wire logic          clk,
  input  wire logic          rd_en,
  input  wire logic          wr_en,
  input  wire logic          and_mode,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] cells [0:(1<<AW)-1];

  // Write-only on unerased cells can only clear bits
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      cells[addr] <= and_mode ? (cells[addr] & wr_data) : wr_data;
    end
    if (rd_en)
    begin
      rd_data <= cells[addr];
    end
  end

endmodule // eeac_mem

// ===== verilog/eeac_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Address is 6 bits, locations 0..63; address bits 7:6 read zero.
// - Data register holds byte to program, and receives fetched byte.
// - Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms.
// - Mode writes are ignored while busy.
// - Reset clears mode to 00 unless programming is in progress.
// - Ready interrupt is a level while enabled, globally enabled and ready.
// - Arm bit clears itself four cycles after being set.
// - Trigger starts programming only within four cycles of arming.
// - Trigger bit reads as busy and clears when programming time ends.
// - Starting a program stalls the CPU for two cycles.
// - Read strobe fetches addressed byte into data register two cycles later.
// - Read strobe stalls the CPU for four cycles.
// - While busy, read strobes and address writes are ignored.
// - Control bits 7:6 read zero; software writes them zero.
// - Reset zeroes irq enable, arm, read strobe and data register.
// - Write-only on an unerased cell leaves the AND of old and new byte.
// - Reset during programming lets the operation finish.
module eeac_ctrl #(
  parameter int unsigned ATOMIC_CYCLES = eeac_pkg::ATOMIC_CYCLES,
  parameter int unsigned SPLIT_CYCLES  = eeac_pkg::SPLIT_CYCLES,
  parameter int unsigned CNT_W         = 17
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [5:0] io_addr,
  input  wire logic       io_we,
  input  wire logic       io_re,
  input  wire logic [7:0] io_wdata,
  input  wire logic       global_irq_enable,
  output logic      [7:0] io_rdata,
  output logic            cpu_stall,
  output logic            ready_irq
);

  // Elaboration checks on counts
  if (ATOMIC_CYCLES < 1 || ATOMIC_CYCLES > (1 << CNT_W)) 
  begin : g_chk_atomic
    $error("ATOMIC_CYCLES does not fit the countdown");
  end
  if (SPLIT_CYCLES < 1 || SPLIT_CYCLES > (1 << CNT_W))
  begin : g_chk_split
    $error("SPLIT_CYCLES does not fit the countdown");
  end

  localparam logic [CNT_W-1:0] LOAD_ATOMIC = CNT_W'(ATOMIC_CYCLES - 1);
  localparam logic [CNT_W-1:0] LOAD_SPLIT  = CNT_W'(SPLIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO    = '0;
  localparam logic [2:0]       ONE3        = 3'h1;
  localparam logic [2:0]       ZERO3       = 3'h0;

  typedef struct packed {
    eeac_pkg::eeac_state_t state;
    logic [CNT_W-1:0]      count;
    logic [5:0]            addr;
    logic [7:0]            data;
    eeac_pkg::eeac_mode_t  mode;
    logic                  irq_en;
    logic [2:0]            arm_cnt;
    logic [5:0]            lat_addr;
    logic [7:0]            lat_data;
    eeac_pkg::eeac_mode_t  lat_mode;
    logic [7:0]            scratch;
    logic                  rd_pending;
    logic                  stall;
    logic [2:0]            stall_left;
    logic [7:0]            rdata;
    logic                  irq;
  } eeac_regs_t;

  eeac_regs_t st;
  eeac_regs_t next_st;

  logic       busy;
  logic       armed;
  logic       ctrl_wr;
  logic       start;
  logic       read_go;
  logic       mem_we;
  logic       mem_and;
  logic [5:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;

  // Decode of software accesses
  assign busy    = (st.state != eeac_pkg::EEAC_ST_IDLE);
  assign armed   = (st.arm_cnt != ZERO3);
  assign ctrl_wr = reset_n && io_we && (io_addr == eeac_pkg::OFS_CTRL);
  assign start   = ctrl_wr && io_wdata[eeac_pkg::BIT_TRIG] && armed && !busy
                   && (st.mode != eeac_pkg::EEAC_MODE_RSVD);
  assign read_go = ctrl_wr && io_wdata[eeac_pkg::BIT_READ] && !busy && !start;

  // Array port: commit uses latched target, reads use live address
  assign mem_we    = (st.state == eeac_pkg::EEAC_ST_COMMIT);
  assign mem_and   = (st.lat_mode == eeac_pkg::EEAC_MODE_WRITE);
  assign mem_addr  = mem_we ? st.lat_addr : st.addr;
  assign mem_wdata = (st.lat_mode == eeac_pkg::EEAC_MODE_ERASE) ?
                     eeac_pkg::ERASED_BYTE : st.lat_data;

  eeac_mem #(
    .AW (eeac_pkg::NVM_AW),
    .DW (eeac_pkg::NVM_DW)
  ) eeac_mem_i (
    .clk      (clk),
    .rd_en    (read_go),
    .wr_en    (mem_we),
    .and_mode (mem_and),
    .addr     (mem_addr),
    .wr_data  (mem_wdata),
    .rd_data  (mem_rdata)
  );

  // Next-state computation
  always_comb
  begin
    next_st = st;
    next_st.rd_pending = read_go;

    // Arm window countdown, rewrite does not extend it
    if (armed)
    begin
      next_st.arm_cnt = st.arm_cnt - ONE3;
    end
    else if (ctrl_wr && io_wdata[eeac_pkg::BIT_ARM])
    begin
      next_st.arm_cnt = eeac_pkg::ARM_WINDOW;
    end

    // Control fields
    if (ctrl_wr)
    begin
      next_st.irq_en = io_wdata[eeac_pkg::BIT_IRQ_EN];
      if (!busy)
      begin
        next_st.mode = eeac_pkg::eeac_mode_t'(
          io_wdata[eeac_pkg::BIT_MODE_HI:eeac_pkg::BIT_MODE_LO]);
      end
    end

    // Address, data and scratch writes
    if (reset_n && io_we && io_addr == eeac_pkg::OFS_ADDR && !busy)
    begin
      next_st.addr = io_wdata[5:0];
    end
    if (st.rd_pending)
    begin
      next_st.data = mem_rdata;
    end
    else if (reset_n && io_we && io_addr == eeac_pkg::OFS_DATA)
    begin
      next_st.data = io_wdata;
    end
    if (reset_n && io_we && io_addr == eeac_pkg::OFS_SCRATCH0)
    begin
      next_st.scratch = io_wdata;
    end

    // CPU stall timing
    if (start)
    begin
      next_st.stall      = 1'b1;
      next_st.stall_left = eeac_pkg::STALL_PROG - ONE3;
    end
    else if (read_go)
    begin
      next_st.stall      = 1'b1;
      next_st.stall_left = eeac_pkg::STALL_READ - ONE3;
    end
    else if (st.stall_left != ZERO3)
    begin
      next_st.stall_left = st.stall_left - ONE3;
    end
    else
    begin
      next_st.stall = 1'b0;
    end

    // Programming sequencer
    case (st.state)
      eeac_pkg::EEAC_ST_IDLE:
      begin
        if (start)
        begin
          next_st.state    = eeac_pkg::EEAC_ST_PROG;
          next_st.lat_addr = st.addr;
          next_st.lat_data = st.data;
          next_st.lat_mode = st.mode;
          next_st.count    = (st.mode == eeac_pkg::EEAC_MODE_ATOMIC) ?
                             LOAD_ATOMIC : LOAD_SPLIT;
        end
      end
      eeac_pkg::EEAC_ST_PROG:
      begin
        if (st.count == CNT_ZERO)
        begin
          next_st.state = eeac_pkg::EEAC_ST_COMMIT;
        end
        else
        begin
          next_st.count = st.count - CNT_W'(1);
        end
      end
      eeac_pkg::EEAC_ST_COMMIT:
      begin
        next_st.state = eeac_pkg::EEAC_ST_IDLE;
      end
      default:
      begin
        next_st.state = eeac_pkg::EEAC_ST_IDLE;
      end
    endcase

    // Registered read port
    if (io_re)
    begin
      case (io_addr)
        eeac_pkg::OFS_ADDR:     next_st.rdata = {eeac_pkg::PAD_ZERO, st.addr};
        eeac_pkg::OFS_DATA:     next_st.rdata = st.data;
        eeac_pkg::OFS_CTRL:     next_st.rdata = {eeac_pkg::PAD_ZERO, st.mode, st.irq_en,
                                                 armed, busy, 1'b0};
        eeac_pkg::OFS_SCRATCH0: next_st.rdata = st.scratch;
        default:                next_st.rdata = 8'h00;
      endcase
    end

    // Level ready interrupt
    next_st.irq = st.irq_en && global_irq_enable && !busy;

    // Synchronous reset; sequencer and its mode survive while busy
    if (!reset_n)
    begin
      next_st.addr       = 6'h00;
      next_st.data       = eeac_pkg::RST_DATA;
      next_st.irq_en     = 1'b0;
      next_st.arm_cnt    = ZERO3;
      next_st.rd_pending = 1'b0;
      next_st.scratch    = eeac_pkg::RST_SCRATCH0;
      next_st.stall      = 1'b0;
      next_st.stall_left = ZERO3;
      next_st.rdata      = 8'h00;
      next_st.irq        = 1'b0;
      if (!busy)
      begin
        next_st.mode     = eeac_pkg::EEAC_MODE_ATOMIC;
        next_st.state    = eeac_pkg::EEAC_ST_IDLE;
        next_st.count    = CNT_ZERO;
        next_st.lat_mode = eeac_pkg::EEAC_MODE_ATOMIC;
        next_st.lat_addr = 6'h00;
        next_st.lat_data = 8'h00;
      end // busy: keep going
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    st <= next_st;
  end

  assign io_rdata  = st.rdata;
  assign cpu_stall = st.stall;
  assign ready_irq = st.irq;

  // Helper: length of the current busy period
  logic [CNT_W:0] busy_len;
  always_ff @(posedge clk)
  begin
    if (!busy)
    begin
      busy_len <= '0;
    end
    else
    begin
      busy_len <= busy_len + (CNT_W+1)'(1);
    end
  end

  logic [CNT_W:0] exp_len;
  assign exp_len = (st.lat_mode == eeac_pkg::EEAC_MODE_ATOMIC) ?
                   (CNT_W+1)'(ATOMIC_CYCLES + 1) : (CNT_W+1)'(SPLIT_CYCLES + 1);

  // Checks
  property p_addr_top_zero;
    @(posedge clk) disable iff (!reset_n)
      (io_re && io_addr == eeac_pkg::OFS_ADDR) |=> (io_rdata[7:6] == 2'h0);
  endproperty
  a_addr_top_zero: assert property (p_addr_top_zero) else $error("address top bits set");

  property p_ctrl_top_zero;
    @(posedge clk) disable iff (!reset_n)
      (io_re && io_addr == eeac_pkg::OFS_CTRL) |=> (io_rdata[7:6] == 2'h0 && io_rdata[0] == 1'b0);
  endproperty
  a_ctrl_top_zero: assert property (p_ctrl_top_zero) else $error("control reserved bits set");

  property p_mode_hold_busy;
    @(posedge clk) (busy && ctrl_wr) |=> (st.mode == $past(st.mode));
  endproperty
  a_mode_hold_busy: assert property (p_mode_hold_busy) else $error("mode changed while busy");

  property p_mode_reset;
    @(posedge clk) (!reset_n && !busy) |=> (st.mode == eeac_pkg::EEAC_MODE_ATOMIC);
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode not cleared by reset");

  property p_arm_clears;
    @(posedge clk) disable iff (!reset_n)
      $rose(armed) |-> armed [*4] ##1 !armed;
  endproperty
  a_arm_clears: assert property (p_arm_clears) else $error("arm window not four cycles");

  property p_trig_needs_arm;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_wr && io_wdata[eeac_pkg::BIT_TRIG] && !armed && !busy) |=> !busy;
  endproperty
  a_trig_needs_arm: assert property (p_trig_needs_arm) else $error("unarmed trigger started");

  property p_busy_len;
    @(posedge clk) disable iff (!reset_n) $fell(busy) |-> (busy_len == exp_len);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("programming time wrong");

  property p_prog_stall;
    @(posedge clk) disable iff (!reset_n)
      start |=> cpu_stall [*2] ##1 !cpu_stall;
  endproperty
  a_prog_stall: assert property (p_prog_stall) else $error("program stall not two cycles");

  property p_read_stall;
    @(posedge clk) disable iff (!reset_n)
      read_go |=> cpu_stall [*4] ##1 !cpu_stall;
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("read stall not four cycles");

  property p_read_fetch;
    @(posedge clk) disable iff (!reset_n)
      read_go |-> ##2 (st.data == eeac_mem_i.cells[$past(st.addr, 2)]);
  endproperty
  a_read_fetch: assert property (p_read_fetch) else $error("fetched byte not in data");

  property p_busy_blocks;
    @(posedge clk) disable iff (!reset_n) busy |=> ($stable(st.addr) && !st.rd_pending);
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) else $error("access while busy");

  property p_irq_level;
    @(posedge clk) disable iff (!reset_n)
      (st.irq_en && global_irq_enable && !busy) |=> ready_irq;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("ready irq missing");

  property p_reset_zero;
    @(posedge clk) !reset_n |=> (!st.irq_en && !armed && st.data == 8'h00);
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset values wrong");

  property p_reset_finishes;
    @(posedge clk) (!reset_n && st.state == eeac_pkg::EEAC_ST_PROG) |=> busy;
  endproperty
  a_reset_finishes: assert property (p_reset_finishes) else $error("reset aborted program");

  // Scenario coverage
  c_start:     cover property (@(posedge clk) start);
  c_read:      cover property (@(posedge clk) read_go);
  c_commit:    cover property (@(posedge clk) mem_we);
  c_reset_bsy: cover property (@(posedge clk) !reset_n && busy);

endmodule // eeac_ctrl

// ===== tb/eeprom_access_controller_test.sv
`timescale 1ns/1ps
// Self-checking bench for the data EEPROM controller
module eeprom_access_controller_test;
  localparam int unsigned N_AT  = 20;
  localparam int unsigned N_SP  = 10;
  localparam int unsigned T_MAX = 2000;

  logic       clk = 1'b0;
  logic       reset_n;
  logic [5:0] io_addr;
  logic       io_we;
  logic       io_re;
  logic [7:0] io_wdata;
  logic       global_irq_enable;
  logic [7:0] io_rdata;
  logic       cpu_stall;
  logic       ready_irq;
  int         n_fail;
  int         n_tests;
  int         cycles;
  logic [7:0] rd_val;

  eeac_ctrl #(
    .ATOMIC_CYCLES (N_AT),
    .SPLIT_CYCLES  (N_SP)
  ) eeac_ctrl_i (
    .clk               (clk),
    .reset_n           (reset_n),
    .io_addr           (io_addr),
    .io_we             (io_we),
    .io_re             (io_re),
    .io_wdata          (io_wdata),
    .global_irq_enable (global_irq_enable),
    .io_rdata          (io_rdata),
    .cpu_stall         (cpu_stall),
    .ready_irq         (ready_irq)
  );

  // Clock, 50 ns period
  always #25 clk = ~clk;

  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == T_MAX)
    begin
      n_fail = n_fail + 1;
      final_report();
    end
  end

  // Verdict and end of run
  task automatic final_report();
    $display("Checks run: %0d, mismatches: %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Drop both strobes, wait n edges, then settle off the edge
  task automatic step(input int n);
    io_we = 1'b0;
    io_re = 1'b0;
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Register write; strobe stays up until the next task drops it
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    io_re    = 1'b0;
    io_we    = 1'b1;
    io_addr  = a;
    io_wdata = d;
    @(posedge clk);
    #5;
  endtask

  // One-cycle register read
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    io_we   = 1'b0;
    io_re   = 1'b1;
    io_addr = a;
    @(posedge clk);
    #5;
    d       = io_rdata;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask

  // Read a register and compare
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    rd(a, rd_val);
    chk(rd_val, exp);
  endtask

  // Read strobe with stall count and data return
  task automatic fetch(input logic [5:0] a, input logic [7:0] exp);
    wr(eeac_pkg::OFS_ADDR, {2'h0, a});
    wr(eeac_pkg::OFS_CTRL, 8'h01);
    chk(cpu_stall, 1'b1);
    step(3);
    chk(cpu_stall, 1'b1);
    step(1);
    chk(cpu_stall, 1'b0);
    rchk(eeac_pkg::OFS_DATA, exp);
  endtask

  // Armed program, busy interference, exact busy length, readback
  task automatic prog(input logic [5:0] a, input logic [7:0] d,
                      input eeac_pkg::eeac_mode_t m, input logic irq,
                      input logic [7:0] exp);
    logic [7:0] c;
    int         n;
    c = {2'h0, m, irq, 3'h0};
    n = (m == eeac_pkg::EEAC_MODE_ATOMIC) ? N_AT : N_SP;
    wr(eeac_pkg::OFS_ADDR, {2'h0, a});
    wr(eeac_pkg::OFS_DATA, d);
    wr(eeac_pkg::OFS_CTRL, c);
    wr(eeac_pkg::OFS_CTRL, c | 8'h04);
    rchk(eeac_pkg::OFS_CTRL, c | 8'h04);
    wr(eeac_pkg::OFS_CTRL, c | 8'h02);
    chk(cpu_stall, 1'b1);
    step(1);
    chk(cpu_stall, 1'b1);
    step(1);
    chk(cpu_stall, 1'b0);
    wr(eeac_pkg::OFS_ADDR, ~{2'h0, a});
    wr(eeac_pkg::OFS_CTRL, (c ^ 8'h10) | 8'h01);
    chk(cpu_stall, 1'b0);
    chk(ready_irq, 1'b0);
    rchk(eeac_pkg::OFS_CTRL, c | 8'h02);
    rchk(eeac_pkg::OFS_ADDR, {2'h0, a});
    rchk(eeac_pkg::OFS_DATA, d);
    step(n - 7);
    rchk(eeac_pkg::OFS_CTRL, c | 8'h02);
    rchk(eeac_pkg::OFS_CTRL, c);
    chk(ready_irq, irq);
    fetch(a, exp);
  endtask

  // Main sequence
  initial
  begin
    n_fail            = 0;
    n_tests           = 0;
    cycles            = 0;
    reset_n           = 1'b0;
    io_addr           = 6'h00;
    io_wdata          = 8'h00;
    global_irq_enable = 1'b0;
    step(10);
    reset_n = 1'b1;
    // Reset values and unmapped places
    rchk(eeac_pkg::OFS_CTRL, 8'h00);
    rchk(eeac_pkg::OFS_DATA, eeac_pkg::RST_DATA);
    rchk(eeac_pkg::OFS_SCRATCH0, eeac_pkg::RST_SCRATCH0);
    rchk(6'h20, 8'h00);
    // Read-only bits and plain storage
    wr(eeac_pkg::OFS_ADDR, 8'hff);
    rchk(eeac_pkg::OFS_ADDR, 8'h3f);
    wr(eeac_pkg::OFS_CTRL, 8'hc0);
    rchk(eeac_pkg::OFS_CTRL, 8'h00);
    wr(eeac_pkg::OFS_SCRATCH0, 8'ha5);
    rchk(eeac_pkg::OFS_SCRATCH0, 8'ha5);
    wr(6'h21, 8'h5a);
    rchk(6'h21, 8'h00);
    // Ready interrupt follows enable and global enable
    global_irq_enable = 1'b1;
    wr(eeac_pkg::OFS_CTRL, 8'h08);
    step(1);
    chk(ready_irq, 1'b1);
    global_irq_enable = 1'b0;
    step(2);
    chk(ready_irq, 1'b0);
    global_irq_enable = 1'b1;
    // Arm window closes after four cycles, late trigger ignored
    wr(eeac_pkg::OFS_CTRL, 8'h04);
    step(3);
    rchk(eeac_pkg::OFS_CTRL, 8'h04);
    rchk(eeac_pkg::OFS_CTRL, 8'h00);
    wr(eeac_pkg::OFS_CTRL, 8'h02);
    chk(cpu_stall, 1'b0);
    rchk(eeac_pkg::OFS_CTRL, 8'h00);
    // Reserved mode does not start
    wr(eeac_pkg::OFS_CTRL, 8'h30);
    wr(eeac_pkg::OFS_CTRL, 8'h34);
    wr(eeac_pkg::OFS_CTRL, 8'h32);
    chk(cpu_stall, 1'b0);
    rchk(eeac_pkg::OFS_CTRL, 8'h34);
    // Atomic, erase and write modes, top location, write-only as AND of old and new
    prog(6'h3f, 8'h5a, eeac_pkg::EEAC_MODE_ATOMIC, 1'b1, 8'h5a);
    prog(6'h3f, 8'h0f, eeac_pkg::EEAC_MODE_WRITE, 1'b0, 8'h0a);
    prog(6'h3f, 8'h00, eeac_pkg::EEAC_MODE_ERASE, 1'b1, eeac_pkg::ERASED_BYTE);
    prog(6'h3f, 8'h3c, eeac_pkg::EEAC_MODE_WRITE, 1'b0, 8'h3c);
    prog(6'h00, 8'ha5, eeac_pkg::EEAC_MODE_ATOMIC, 1'b0, 8'ha5);
    // Reset in mid-erase: operation finishes, mode kept
    wr(eeac_pkg::OFS_ADDR, 8'h07);
    wr(eeac_pkg::OFS_CTRL, 8'h10);
    wr(eeac_pkg::OFS_CTRL, 8'h14);
    wr(eeac_pkg::OFS_CTRL, 8'h12);
    reset_n = 1'b0;
    step(1);
    reset_n = 1'b1;
    rchk(eeac_pkg::OFS_CTRL, 8'h12);
    step(N_SP);
    rchk(eeac_pkg::OFS_CTRL, 8'h10);
    reset_n = 1'b0;
    step(1);
    reset_n = 1'b1;
    rchk(eeac_pkg::OFS_CTRL, 8'h00);
    rchk(eeac_pkg::OFS_DATA, 8'h00);
    fetch(6'h07, eeac_pkg::ERASED_BYTE);
    final_report();
  end
endmodule // eeprom_access_controller_test
